// ==== inc/flrb_pkg.sv ====
// Package: record layout, sizes and carrier types for the fault log record builder
package flrb_pkg;
  localparam int unsigned REC_LEN          = 147;
  localparam int unsigned MUX_LAST_STEP    = 25;
  localparam int unsigned EVENT_PAGES      = 6;
  localparam int unsigned POS_TINT_HI      = 20;
  localparam int unsigned POS_TINT_LO      = 21;
  localparam int unsigned POS_TEXT_PK_HI   = 23;
  localparam int unsigned POS_TEXT_PK_LO   = 24;
  localparam int unsigned POS_VOUT_HI      = 27;
  localparam int unsigned POS_VOUT_LO      = 28;
  localparam int unsigned POS_IOUT_HI      = 31;
  localparam int unsigned POS_ICHAN_HI     = 33;
  localparam int unsigned POS_VIN_HI       = 35;
  localparam int unsigned POS_IIN_HI       = 37;
  localparam int unsigned POS_IIN_LO       = 38;
  localparam int unsigned POS_STATUS_VOUT  = 39;
  localparam logic [7:0]  RESERVED_BYTE    = 8'h00;
  localparam logic [15:0] PEAK_RESET       = 16'h8000;

  typedef struct packed {
    logic [15:0] temp_int;
    logic [15:0] temp_ext;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] ichan;
    logic [15:0] vin;
    logic [15:0] iin;
    logic [7:0]  status_vout;
  } flrb_telem_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [7:0]  data;
  } flrb_nvm_wr_type;
endpackage

// ==== verilog/flrb_peak_track.sv ====
// Linear-11 peak tracker with clear
`timescale 1ns/1ps
module flrb_peak_track
  import flrb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic        sample_i,
  input  wire logic [15:0] value_i,
  input  wire logic        clear_i,
  output logic      [15:0] peak_o
);
  logic [15:0] peak_reg;
  logic signed [63:0] new_val;
  logic signed [63:0] old_val;
  logic        greater;
  logic        first_reg;

  // Linear-11: signed 5-bit exponent, signed 11-bit mantissa
  // Scaled by 2^16 so fraction bits count; 64 bits cannot overflow
  function automatic logic signed [63:0] lin11_value(input logic [15:0] w);
    logic signed [63:0] m;
    int                 sh;
    m = 64'(signed'(w[10:0]));
    sh = int'(signed'(w[15:11])) + 16;
    lin11_value = m <<< sh;
  endfunction

  assign new_val = lin11_value(value_i);
  assign old_val = lin11_value(peak_reg);
  assign greater = first_reg || (new_val > old_val);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      peak_reg  <= PEAK_RESET;
      first_reg <= 1'b1;
    end else if (ce_i) begin
      if (clear_i) begin
        peak_reg  <= sample_i ? value_i : PEAK_RESET;
        first_reg <= !sample_i;
      end else if (sample_i && greater) begin
        peak_reg  <= value_i;
        first_reg <= 1'b0;
      end
    end
  end

  assign peak_o = peak_reg;
endmodule

// ==== verilog/flrb_top.sv ====
// Fault log record builder: mux-pass completion, record commit, block readback
`timescale 1ns/1ps
module flrb_top
  import flrb_pkg::*;
#(
  parameter int unsigned STEP_W = 5
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 ce_i,
  input  wire logic                 adc_step_done_i,
  input  wire logic [STEP_W-1:0]    adc_step_i,
  input  wire flrb_telem_type       telem_i,
  input  wire logic                 fault_i,
  input  wire logic                 peak_clear_command_i,
  input  wire logic [7:0]           old_page_data_i,
  output flrb_nvm_wr_type           nvm_wr_o,
  input  wire logic                 nvm_ready_i,
  input  wire logic                 fault_log_block_command_i,
  input  wire logic [7:0]           rd_addr_i,
  output logic      [7:0]           rd_data_o,
  output logic      [7:0]           block_len_o,
  output logic                      busy_o,
  output logic                      log_valid_o
);
  typedef enum {S_IDLE, S_FINISH, S_WRITE} flrb_state_type;

  logic           rst_s1_reg;
  logic           rst_b_reg;
  flrb_state_type state_reg;
  flrb_state_type state_next;
  flrb_telem_type snap_reg;
  logic [7:0]     wr_addr_reg;
  logic [7:0]     wr_addr_next;
  logic           log_valid_reg;
  logic [7:0]     rd_data_reg;
  logic [7:0]     len_reg;
  logic [15:0]    ext_peak;
  logic           last_step;
  logic           write_done;
  logic [7:0]     wr_byte;
  logic [7:0]     mem_reg [REC_LEN];
  logic           wr_take;
  logic [15:0]    peak_snap_reg;
  logic           rd_hit;
  logic [7:0]     rd_byte;
  flrb_nvm_wr_type nvm_wr_reg;
  flrb_nvm_wr_type nvm_wr_next;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_reg <= 1'b0;
      rst_b_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_b_reg  <= rst_s1_reg;
    end
  end

  flrb_peak_track u_ext_peak (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_reg),
    .ce_i     (ce_i),
    .sample_i (adc_step_done_i),
    .value_i  (telem_i.temp_ext),
    .clear_i  (peak_clear_command_i),
    .peak_o   (ext_peak)
  );

  assign last_step  = adc_step_done_i && (adc_step_i == STEP_W'(MUX_LAST_STEP));
  assign wr_take    = (state_reg == S_WRITE) && nvm_ready_i;
  assign write_done = wr_take && (wr_addr_reg == 8'(REC_LEN - 1));

  always_comb begin
    state_next   = state_reg;
    wr_addr_next = wr_addr_reg;
    case (state_reg)
      S_IDLE: begin
        if (fault_i) begin
          state_next = last_step ? S_WRITE : S_FINISH;
        end
        wr_addr_next = 8'h00;
      end
      S_FINISH: begin
        if (last_step) begin
          state_next = S_WRITE;
        end
      end
      S_WRITE: begin
        if (nvm_ready_i) begin
          wr_addr_next = wr_addr_reg + 8'h01;
        end
        if (write_done) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Record byte image for the current write address
  always_comb begin
    case (wr_addr_reg)
      8'(POS_TINT_HI):      wr_byte = snap_reg.temp_int[15:8];
      8'(POS_TINT_LO):      wr_byte = snap_reg.temp_int[7:0];
      8'(POS_TEXT_PK_HI):   wr_byte = peak_snap_reg[15:8];
      8'(POS_TEXT_PK_LO):   wr_byte = peak_snap_reg[7:0];
      8'(POS_VOUT_HI):      wr_byte = snap_reg.vout[15:8];
      8'(POS_VOUT_LO):      wr_byte = snap_reg.vout[7:0];
      8'(POS_IOUT_HI):      wr_byte = snap_reg.iout[15:8];
      8'(POS_IOUT_HI + 1):  wr_byte = snap_reg.iout[7:0];
      8'(POS_ICHAN_HI):     wr_byte = snap_reg.ichan[15:8];
      8'(POS_ICHAN_HI + 1): wr_byte = snap_reg.ichan[7:0];
      8'(POS_VIN_HI):       wr_byte = snap_reg.vin[15:8];
      8'(POS_VIN_HI + 1):   wr_byte = snap_reg.vin[7:0];
      8'(POS_IIN_HI):       wr_byte = snap_reg.iin[15:8];
      8'(POS_IIN_LO):       wr_byte = snap_reg.iin[7:0];
      8'(POS_STATUS_VOUT):  wr_byte = snap_reg.status_vout;
      default: begin
        if (wr_addr_reg < 8'(POS_TINT_HI) || wr_addr_reg > 8'(POS_STATUS_VOUT + 1)) begin
          wr_byte = old_page_data_i; // Other header bytes and older pages
        end else begin
          wr_byte = RESERVED_BYTE;
        end
      end
    endcase
  end

  // State and write pointer
  always_ff @(posedge clk_i or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      state_reg   <= S_IDLE;
      wr_addr_reg <= 8'h00;
    end else if (ce_i) begin
      state_reg   <= state_next;
      wr_addr_reg <= wr_addr_next;
    end
  end

  // One write per byte taken, so each position is programmed once
  assign nvm_wr_next = wr_take ? {1'b1, wr_addr_reg, wr_byte} : '0;

  always_ff @(posedge clk_i or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      nvm_wr_reg <= '0;
    end else if (ce_i) begin
      nvm_wr_reg <= nvm_wr_next;
    end
  end

  // Snapshots hold still during the write so no word is torn across bytes
  always_ff @(posedge clk_i or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      snap_reg      <= '0;
      peak_snap_reg <= PEAK_RESET;
    end else if (ce_i && state_reg != S_WRITE) begin
      peak_snap_reg <= ext_peak;
      if (adc_step_done_i) begin
        snap_reg <= telem_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      log_valid_reg <= 1'b0;
    end else if (ce_i && write_done) begin
      log_valid_reg <= 1'b1;
    end
  end

  // Readback image, one byte per record position
  for (genvar i = 0; i < REC_LEN; i++) begin : g_mem
    always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
        mem_reg[i] <= RESERVED_BYTE;
      end else if (ce_i && wr_take && wr_addr_reg == 8'(i)) begin
        mem_reg[i] <= wr_byte;
      end
    end
  end

  // Record length follows the committed flag
  always_ff @(posedge clk_i or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      len_reg <= 8'h00;
    end else if (ce_i) begin
      len_reg <= log_valid_reg ? 8'(REC_LEN) : 8'h00;
    end
  end

  // Zero when nothing is logged or the position lies past the record
  assign rd_hit  = log_valid_reg && (rd_addr_i < 8'(REC_LEN));
  assign rd_byte = rd_hit ? mem_reg[rd_addr_i] : 8'h00;

  always_ff @(posedge clk_i or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      rd_data_reg <= 8'h00;
    end else if (ce_i && fault_log_block_command_i) begin
      rd_data_reg <= rd_byte;
    end
  end

  assign nvm_wr_o    = nvm_wr_reg;
  assign rd_data_o   = rd_data_reg;
  assign block_len_o = len_reg;
  assign busy_o      = (state_reg != S_IDLE);
  assign log_valid_o = log_valid_reg;
endmodule

// ==== dv/flrb_nvm_model.sv ====
// NVM sink model: stores committed record bytes, stalls one cycle in four
`timescale 1ns/1ps
module flrb_nvm_model
  import flrb_pkg::*;
(
  input  wire logic            clk_i,
  input  wire flrb_nvm_wr_type wr_i,
  output logic                 ready_o
);
  logic [7:0] mem [0:REC_LEN-1];
  logic [1:0] cnt = '0;
  int         wr_count = 0;
  assign ready_o = (cnt != 2'h3);
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    if (wr_i.valid === 1'b1) begin
      mem[wr_i.addr] <= wr_i.data;
      wr_count <= wr_count + 1;
    end
  end
endmodule

// ==== dv/flrb_checker.sv ====
// Port checker for the fault log record builder
`timescale 1ns/1ps
module flrb_checker
  import flrb_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_b_i,
  input wire logic            ce_i,
  input wire logic            fault_i,
  input wire logic            fault_log_block_command_i,
  input wire logic [7:0]      rd_addr_i,
  input wire logic [7:0]      rd_data_o,
  input wire logic [7:0]      block_len_o,
  input wire logic            busy_o,
  input wire logic            log_valid_o,
  input wire flrb_nvm_wr_type nvm_wr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire rd = ce_i && fault_log_block_command_i;
  a_len_legal: assert property (block_len_o == 8'h00 || block_len_o == 8'h93)
    else $error("block length illegal");
  a_len_after: assert property ($rose(log_valid_o) |=> block_len_o == 8'h93)
    else $error("block length not set after commit");
  a_rd_nolog: assert property (rd && !log_valid_o |=> rd_data_o == 8'h00)
    else $error("read data without log");
  a_rd_oob: assert property (rd && rd_addr_i >= 8'h93 |=> rd_data_o == 8'h00)
    else $error("read past record end");
  a_rd_resv: assert property (rd && rd_addr_i inside {8'h19, 8'h1A, 8'h1D, 8'h1E, 8'h28}
    |=> rd_data_o == 8'h00)
    else $error("reserved byte read nonzero");
  a_wr_resv: assert property (nvm_wr_o.valid && nvm_wr_o.addr inside {8'h19, 8'h1A, 8'h1D,
    8'h1E, 8'h28} |-> nvm_wr_o.data == 8'h00)
    else $error("reserved byte written nonzero");
  a_wr_range: assert property (nvm_wr_o.valid |-> $past(busy_o) && nvm_wr_o.addr < 8'h93)
    else $error("write outside record");
  a_fault_taken: assert property (ce_i && fault_i && !busy_o |=> busy_o)
    else $error("fault not taken");
  c_commit: cover property ($rose(log_valid_o));
  c_refused: cover property (fault_i && busy_o);
  c_read: cover property (rd && log_valid_o);
endmodule
bind flrb_top flrb_checker flrb_checker_inst (.*);

// ==== dv/tb_top.sv ====
// Testbench: capture at mid-pass fault, commit to NVM, readback of layout
`timescale 1ns/1ps
module tb_top;
  import flrb_pkg::*;
  localparam logic [7:0] OLD_BYTE = 8'hA5;
  logic            clk_i = 0, rst_b_i = 0, ce_i = 1, sd = 0, fault = 0, clr = 0, cmd = 0;
  logic [4:0]      step = '0;
  logic [7:0]      ra = '0, rdd, blen, old_b;
  flrb_telem_type  tm = '0;
  flrb_nvm_wr_type wr;
  logic            ready, busy, lv;
  int              failures = 0, checks_done = 0, i;
  assign old_b = OLD_BYTE;
  initial forever #4 clk_i = ~clk_i;
  flrb_top flrb_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .adc_step_done_i(sd), .adc_step_i(step), .telem_i(tm), .fault_i(fault),
    .peak_clear_command_i(clr), .old_page_data_i(old_b), .nvm_wr_o(wr),
    .nvm_ready_i(ready), .fault_log_block_command_i(cmd), .rd_addr_i(ra),
    .rd_data_o(rdd), .block_len_o(blen), .busy_o(busy), .log_valid_o(lv));
  flrb_nvm_model flrb_nvm_model_inst (.clk_i(clk_i), .wr_i(wr), .ready_o(ready));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task pulse_step(input logic [4:0] s, input logic [15:0] ext);
    @(posedge clk_i);
    sd <= 1'b1;
    step <= s;
    tm <= '{{8'h14, 3'h0, s}, ext, {8'h1B, 3'h0, s}, {8'h1F, 3'h0, s}, {8'h21, 3'h0, s},
      {8'h23, 3'h0, s}, {8'h25, 3'h0, s}, 8'h27};
    @(posedge clk_i);
    sd <= 1'b0;
  endtask
  task rd(input logic [7:0] p);
    @(posedge clk_i);
    cmd <= 1'b1;
    ra <= p;
    @(posedge clk_i);
    cmd <= 1'b0;
    #1;
  endtask
  function automatic logic [7:0] exp_b(input logic [7:0] p);
    if (p < 8'd20 || p > 8'd40) return OLD_BYTE;
    if (p inside {8'd20, 8'd23, 8'd27, 8'd31, 8'd33, 8'd35, 8'd37}) return p;
    if (p inside {8'd21, 8'd28, 8'd32, 8'd34, 8'd36, 8'd38}) return 8'h19;
    if (p == 8'd24) return 8'h30;
    if (p == 8'd39) return 8'h27;
    return 8'h00;
  endfunction
  task t_empty;
    rd(8'd20);
    chk(rdd, 8'h00);
    chk(blen, 8'h00);
  endtask
  task t_capture;
    pulse_step(5'd5, 16'h17F0);
    @(posedge clk_i) clr <= 1'b1;
    @(posedge clk_i) clr <= 1'b0;
    for (i = 10; i < 15; i++) pulse_step(i[4:0], 16'h1710);
    @(posedge clk_i) fault <= 1'b1;
    @(posedge clk_i) fault <= 1'b0;
    for (i = 15; i < 25; i++) pulse_step(i[4:0], (i == 20) ? 16'h1730 : 16'h1710);
    #1;
    chk(8'(busy), 8'h01);
    chk(8'(flrb_nvm_model_inst.wr_count), 8'h00);
    @(posedge clk_i) fault <= 1'b1;
    @(posedge clk_i) fault <= 1'b0;
    pulse_step(5'd25, 16'h1710);
    for (i = 0; i < 2000 && lv !== 1'b1; i++) @(posedge clk_i);
    if (lv !== 1'b1) begin
      chk(8'(lv), 8'h01);
      finish_test();
    end
    repeat (4) @(posedge clk_i);
    #1;
    chk(blen, 8'h93);
    chk(8'(busy), 8'h00);
    chk(8'(flrb_nvm_model_inst.wr_count), 8'h93);
  endtask
  task t_layout;
    for (int p = 0; p < 147; p++) begin
      chk(flrb_nvm_model_inst.mem[p], exp_b(p[7:0]));
      rd(p[7:0]);
      chk(rdd, exp_b(p[7:0]));
    end
    rd(8'd147);
    chk(rdd, 8'h00);
  endtask
  task t_reset;
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(blen, 8'h00);
    chk(8'(lv), 8'h00);
    rd(8'd27);
    chk(rdd, 8'h00);
    @(posedge clk_i);
    ce_i  <= 1'b0;
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    chk(8'(busy), 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_empty();
    t_capture();
    t_layout();
    t_reset();
    finish_test();
  end
endmodule
